/* hw/lss_hold_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module lss_hold_timer #(
   parameter int WIDTH = 16,
   parameter int LIMIT = 20
) (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic run,
   output logic      fire
);

   logic [WIDTH-1:0] cnt_q;

   // Counts while run holds; restarts as soon as it drops
   always_ff @(posedge ref_clk)
   begin
      if (reset || !run)
         cnt_q <= '0;
      else if (cnt_q != WIDTH'(LIMIT))
         cnt_q <= cnt_q + WIDTH'(1);
   end

   // Single pulse on reaching the limit, so a long hold fires once
   assign fire = run && (cnt_q == WIDTH'(LIMIT - 1));

endmodule : lss_hold_timer
`default_nettype wire

/* hw/lss_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lss_cfg.svh"
module lss_top
   import lss_pkg::*;
#(
   parameter int LAT_CYCLES = (`LSS_LAT_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS,
   parameter int OFF_CYCLES = (`LSS_OFF_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS
) (
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire logic                 en_set,
   input  wire logic [`LSS_SINKS-1:0] sink_unterminated,
   output lss_drive_t                main_sink_group,
   output lss_drive_t                sub_sink_group,
   output logic                      pump_force_2x,
   output logic                      shutdown,
   output logic [3:0]                range_select,
   output logic [2:0]                cur_addr
);

   // ************************************************************
   // Pin edges and burst counting
   // ************************************************************
   lss_state_t            state_q;
   logic                  pin_q;
   logic                  rise;
   logic [`LSS_CNT_W-1:0] burst_cnt_q;
   logic                  lat_fire;
   logic                  off_fire;
   logic                  lat_data;
   logic                  lat_addr;
   logic [2:0]            addr_q;
   logic [3:0]            main_lvl_q;
   logic [3:0]            sub_lvl_q;
   logic [3:0]            range_q;
   logic [3:0]            low_q;
   logic [3:0]            data_code;
   logic                  low_active;
   lss_drive_t            main_d;
   lss_drive_t            sub_d;
   lss_scale_t            scale;

   // Previous pin level; the pin is already in this clock's domain
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pin_q <= 1'b0;
      else
         pin_q <= en_set;
   end

   assign rise = en_set && !pin_q;

   // Saturating count so an over-long burst stays recognisable
   always_ff @(posedge ref_clk)
   begin
      if (reset || off_fire || lat_fire)
         burst_cnt_q <= `LSS_CNT_ZERO;
      else if (rise && burst_cnt_q != `LSS_CNT_SAT)
         burst_cnt_q <= burst_cnt_q + `LSS_CNT_ONE;
   end

   // ************************************************************
   // Timeouts
   // ************************************************************
   // Latch: pin held high after a burst
   lss_hold_timer #(
      .WIDTH (8),
      .LIMIT (LAT_CYCLES)
   ) u_latch_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .run     (pin_q && en_set && burst_cnt_q != `LSS_CNT_ZERO),
      .fire    (lat_fire)
   );

   // Shutdown: pin held low while running
   lss_hold_timer #(
      .WIDTH (16),
      .LIMIT (OFF_CYCLES)
   ) u_off_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .run     (!pin_q && !en_set && state_q == LSS_ST_ON),
      .fire    (off_fire)
   );

   // Burst classification; above 21 neither flag rises
   assign lat_data  = lat_fire && burst_cnt_q <= `LSS_DATA_MAX;
   assign lat_addr  = lat_fire && burst_cnt_q > `LSS_ADDR_BASE
                      && burst_cnt_q <= `LSS_ADDR_MAX;
   assign data_code = burst_cnt_q[3:0] - 4'h1;

   // ************************************************************
   // Run state
   // ************************************************************
   // Off until the first edge; long low drops back to off
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         state_q <= LSS_ST_OFF;
      else
         unique case (state_q)
            LSS_ST_OFF:
               if (rise)
                  state_q <= LSS_ST_ON;
            LSS_ST_ON:
               if (off_fire)
                  state_q <= LSS_ST_OFF;
            default:
               state_q <= LSS_ST_OFF;
         endcase
   end

   // ************************************************************
   // Address and data registers
   // ************************************************************
   // Address stays until the next address burst or a shutdown
   always_ff @(posedge ref_clk)
   begin
      if (reset || off_fire)
         addr_q <= `LSS_ADDR_ALL;
      else if (lat_addr)
         addr_q <= 3'(burst_cnt_q - `LSS_ADDR_BASE);
   end

   // Main level: shared or main-only address
   always_ff @(posedge ref_clk)
   begin
      if (reset || off_fire)
         main_lvl_q <= `LSS_CODE_ONE;
      else if (lat_data && (addr_q == `LSS_ADDR_ALL || addr_q == `LSS_ADDR_MAIN))
         main_lvl_q <= data_code;
   end

   // Sub level: shared or sub-only address
   always_ff @(posedge ref_clk)
   begin
      if (reset || off_fire)
         sub_lvl_q <= `LSS_CODE_ONE;
      else if (lat_data && (addr_q == `LSS_ADDR_ALL || addr_q == `LSS_ADDR_SUB))
         sub_lvl_q <= data_code;
   end

   // Range select; codes above 4 have no meaning and are dropped
   always_ff @(posedge ref_clk)
   begin
      if (reset || off_fire)
         range_q <= `LSS_RANGE_20;
      else if (lat_data && addr_q == `LSS_ADDR_RANGE && data_code <= `LSS_RANGE_LOW)
         range_q <= data_code;
   end

   // Low-current register
   always_ff @(posedge ref_clk)
   begin
      if (reset || off_fire)
         low_q <= `LSS_CODE_ONE;
      else if (lat_data && addr_q == `LSS_ADDR_LOW)
         low_q <= data_code;
   end

   // ************************************************************
   // Drive decode
   // ************************************************************
   assign low_active = (range_q == `LSS_RANGE_LOW);

   // Column choice leaves the level code alone
   always_comb
   begin
      unique case (range_q)
         `LSS_RANGE_30: scale = LSS_SCALE_30;
         `LSS_RANGE_15: scale = LSS_SCALE_15;
         default:       scale = LSS_SCALE_20;
      endcase
   end

   // Group commands; low mode overrides stored levels
   always_comb
   begin
      main_d          = '0;
      sub_d           = '0;
      main_d.scale    = scale;
      sub_d.scale     = scale;
      main_d.level    = main_lvl_q;
      sub_d.level     = sub_lvl_q;
      main_d.low_mode = low_active;
      sub_d.low_mode  = low_active;
      if (state_q == LSS_ST_OFF)
      begin
         main_d.on = 1'b0;
         sub_d.on  = 1'b0;
      end
      else if (low_active)
      begin
         main_d.level    = `LSS_CODE_OFF;
         sub_d.level     = `LSS_CODE_OFF;
         main_d.low_step = low_q[1:0];
         sub_d.low_step  = low_q[1:0];
         main_d.on = low_q[3:2] == `LSS_LOW_MAIN || low_q[3:2] == `LSS_LOW_BOTH;
         sub_d.on  = low_q[3:2] == `LSS_LOW_SUB || low_q[3:2] == `LSS_LOW_BOTH;
      end
      else
      begin
         // Code 16 carries no current
         main_d.on = main_lvl_q != `LSS_CODE_OFF;
         sub_d.on  = sub_lvl_q != `LSS_CODE_OFF;
      end
   end

   // Registered drive so the sinks never see decode glitches
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         main_sink_group <= '0;
         sub_sink_group  <= '0;
      end
      else
      begin
         main_sink_group <= main_d;
         sub_sink_group  <= sub_d;
      end
   end

   // Open or grounded sink pushes the pump to doubling while the link is on
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pump_force_2x <= 1'b0;
      else
         pump_force_2x <= (state_q == LSS_ST_ON) && (|sink_unterminated);
   end

   // Status view of internal state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         shutdown     <= 1'b1;
         range_select <= `LSS_RANGE_20;
         cur_addr     <= `LSS_ADDR_ALL;
      end
      else
      begin
         shutdown     <= (state_q == LSS_ST_OFF);
         range_select <= range_q;
         cur_addr     <= addr_q;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_shutdown_clears: assert property (
      off_fire |=> (range_q == `LSS_RANGE_20 && low_q == `LSS_CODE_ONE
                    && main_lvl_q == `LSS_CODE_ONE && addr_q == `LSS_ADDR_ALL))
      else $error("shutdown did not reset registers");

   a_default_column: assert property (
      (range_q == `LSS_RANGE_20) |=> main_sink_group.scale == LSS_SCALE_20)
      else $error("default range not 20mA column");

   a_addr_latch: assert property (
      lat_addr |=> addr_q == 3'($past(burst_cnt_q) - `LSS_ADDR_BASE))
      else $error("address not taken from edge count");

   a_long_ignored: assert property (
      (lat_fire && burst_cnt_q > `LSS_ADDR_MAX) |=>
         ($stable(addr_q) && $stable(range_q) && $stable(low_q)
          && $stable(main_lvl_q) && $stable(sub_lvl_q)))
      else $error("over-long burst changed state");

   a_range_write: assert property (
      (lat_data && addr_q == `LSS_ADDR_RANGE && data_code == `LSS_RANGE_30)
      |=> ##1 (main_sink_group.scale == LSS_SCALE_30))
      else $error("range write did not select 30mA column");

   a_keep_level: assert property (
      ($changed(range_q) && !low_active && state_q == LSS_ST_ON)
      |=> main_sink_group.level == $past(main_lvl_q))
      else $error("level code lost on range change");

   a_shared_write: assert property (
      (lat_data && addr_q == `LSS_ADDR_ALL) |=> (main_lvl_q == sub_lvl_q))
      else $error("shared write did not reach both groups");

   a_low_off: assert property (
      (low_active && low_q[3:2] == `LSS_LOW_OFF)
      |=> (!main_sink_group.on && !sub_sink_group.on))
      else $error("low codes 1-4 left a group on");

   // Only low_q, range_q and state_q may move the drive here; level writes must not
   a_low_ignores: assert property (
      (low_active && state_q == LSS_ST_ON && $stable(low_q) && $stable(range_q)
       && $stable(state_q))
      |=> $stable(main_sink_group))
      else $error("level write affected low-current mode");

   a_force_2x: assert property (
      ((|sink_unterminated) && state_q == LSS_ST_ON) |=> pump_force_2x)
      else $error("unterminated sink did not force doubling");

   a_repeat_data: assert property (
      lat_data |=> $stable(addr_q))
      else $error("data burst moved the address");

endmodule : lss_top
`default_nettype wire

/* pkg/lss_cfg.svh */
`ifndef LSS_CFG_SVH
`define LSS_CFG_SVH

// ************************************************************
// Timing
// ************************************************************
`define LSS_CLK_NS      25
`define LSS_LAT_NS      500
`define LSS_OFF_NS      500000

// ************************************************************
// Edge counts
// ************************************************************
`define LSS_CNT_W       5
`define LSS_CNT_ZERO    5'h00
`define LSS_CNT_ONE     5'h01
`define LSS_DATA_MAX    5'h10
`define LSS_ADDR_BASE   5'h10
`define LSS_ADDR_MAX    5'h15
`define LSS_CNT_SAT     5'h16

// ************************************************************
// Addresses
// ************************************************************
`define LSS_ADDR_ALL    3'h1
`define LSS_ADDR_MAIN   3'h2
`define LSS_ADDR_SUB    3'h3
`define LSS_ADDR_RANGE  3'h4
`define LSS_ADDR_LOW    3'h5

// ************************************************************
// Register codes, held as code minus one, and sink count
// ************************************************************
`define LSS_CODE_ONE    4'h0
`define LSS_CODE_OFF    4'hF
`define LSS_RANGE_20    4'h0
`define LSS_RANGE_30    4'h1
`define LSS_RANGE_15    4'h2
`define LSS_RANGE_LOW   4'h3
`define LSS_LOW_OFF     2'h0
`define LSS_LOW_SUB     2'h1
`define LSS_LOW_MAIN    2'h2
`define LSS_LOW_BOTH    2'h3
`define LSS_SINKS       6

`endif

/* pkg/lss_pkg.sv */
`default_nettype none
package lss_pkg;

   // Link state, one-hot
   typedef enum logic [1:0] {
      LSS_ST_OFF = 2'h1,
      LSS_ST_ON  = 2'h2
   } lss_state_t;

   // Full-scale column, one-hot
   typedef enum logic [2:0] {
      LSS_SCALE_20 = 3'h1,
      LSS_SCALE_30 = 3'h2,
      LSS_SCALE_15 = 3'h4
   } lss_scale_t;

   // Drive command for one sink group
   typedef struct packed {
      logic       on;
      logic       low_mode;
      lss_scale_t scale;
      logic [3:0] level;
      logic [1:0] low_step;
   } lss_drive_t;

endpackage : lss_pkg
`default_nettype wire

/* verif/lss_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Host that pulses the control pin
// ************************************************************
module lss_host_model #(
   parameter int LAT = 4
) (
   input  wire logic ref_clk,
   output var logic  en_set
);

   // Pin rests low until the first burst
   initial en_set = 1'b0;

   // Burst of n rising edges, then held high past the latch pause
   // Ends off the edge so callers sample settled outputs
   task automatic burst(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk);
         #1 en_set = 1'b0;
         @(posedge ref_clk);
         #1 en_set = 1'b1;
      end
      repeat (LAT + 3) @(posedge ref_clk);
      #2;
   endtask : burst

   // Address burst then one data burst
   task automatic write(input int a, input int d);
      burst(a);
      burst(d);
   endtask : write

   // Pin parked low for n cycles
   task automatic idle_low(input int n);
      @(posedge ref_clk);
      #1 en_set = 1'b0;
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : idle_low

endmodule : lss_host_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Self-checking bench
// ************************************************************
module testbench import lss_pkg::*;;

   localparam int LAT   = 4;
   localparam int OFF   = 50;
   localparam int LIMIT = 6000;

   logic       ref_clk;
   logic       reset;
   wire logic  en_set;
   logic [5:0] sink_unterminated;
   lss_drive_t main_g;
   lss_drive_t sub_g;
   logic       pump;
   logic       shut;
   logic [3:0] range_q;
   logic [2:0] addr_q;
   int         err_count;
   int         check_count;
   int         cyc;

   // Short timeouts keep the shutdown case cheap
   lss_top #(.LAT_CYCLES(LAT), .OFF_CYCLES(OFF)) dut_u (
      .ref_clk          (ref_clk),
      .reset            (reset),
      .en_set           (en_set),
      .sink_unterminated(sink_unterminated),
      .main_sink_group  (main_g),
      .sub_sink_group   (sub_g),
      .pump_force_2x    (pump),
      .shutdown         (shut),
      .range_select     (range_q),
      .cur_addr         (addr_q)
   );

   lss_host_model #(.LAT(LAT)) host_u (
      .ref_clk(ref_clk),
      .en_set (en_set)
   );

   // Clock and hang guard
   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;
   initial cyc = 0;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Normal-mode group drive: level held as code minus one
   task automatic chk_grp(input lss_drive_t g, input int c, input lss_scale_t sc);
      chk({g.on, g.low_mode, g.scale, g.level}, {c != 16, 1'b0, sc, 4'(c - 1)});
   endtask : chk_grp

   task automatic t_default;
      chk({shut, range_q, addr_q}, {1'b1, 4'h0, 3'h1});
      host_u.burst(5);
      chk_grp(main_g, 5, LSS_SCALE_20);
      chk_grp(sub_g, 5, LSS_SCALE_20);
      chk(shut, 1'b0);
   endtask : t_default

   task automatic t_range;
      host_u.write(20, 2);
      chk(addr_q, 3'h4);
      chk(range_q, 4'h1);
      chk_grp(main_g, 5, LSS_SCALE_30);
      host_u.burst(3);
      chk_grp(sub_g, 5, LSS_SCALE_15);
      host_u.burst(7);
      chk(range_q, 4'h2);
      host_u.burst(1);
      chk_grp(main_g, 5, LSS_SCALE_20);
      host_u.write(17, 3);
      chk(addr_q, 3'h1);
      chk_grp(main_g, 3, LSS_SCALE_20);
      chk_grp(sub_g, 3, LSS_SCALE_20);
   endtask : t_range

   task automatic t_groups;
      host_u.write(18, 9);
      chk_grp(main_g, 9, LSS_SCALE_20);
      chk_grp(sub_g, 3, LSS_SCALE_20);
      host_u.write(19, 16);
      chk(addr_q, 3'h3);
      chk_grp(sub_g, 16, LSS_SCALE_20);
      chk_grp(main_g, 9, LSS_SCALE_20);
   endtask : t_groups

   // Every low code; level fields read 15, step from the low bits
   task automatic t_low;
      logic [3:0] s;
      host_u.write(20, 4);
      chk(range_q, 4'h3);
      host_u.burst(21);
      chk(addr_q, 3'h5);
      for (int k = 1; k <= 16; k++)
      begin
         s = 4'(k - 1);
         host_u.burst(k);
         chk({main_g.on, main_g.low_mode, main_g.level, main_g.low_step},
             {s[3], 1'b1, 4'hF, s[1:0]});
         chk({sub_g.on, sub_g.low_mode, sub_g.level, sub_g.low_step},
             {s[2], 1'b1, 4'hF, s[1:0]});
      end
      host_u.write(17, 2);
      chk({main_g.on, main_g.low_mode, main_g.level}, {1'b1, 1'b1, 4'hF});
      host_u.write(20, 1);
      chk_grp(main_g, 2, LSS_SCALE_20);
   endtask : t_low

   // Oversized burst must leave address and contents alone
   task automatic t_over;
      host_u.burst(23);
      chk(addr_q, 3'h4);
      chk(range_q, 4'h0);
      chk_grp(main_g, 2, LSS_SCALE_20);
   endtask : t_over

   // Each sink on its own must force doubling, so no flag bit goes untested
   task automatic t_pump;
      for (int i = 0; i < 6; i++)
      begin
         @(posedge ref_clk);
         #1 sink_unterminated = 6'h01 << i;
         repeat (2) @(posedge ref_clk);
         #2 chk(pump, 1'b1);
         @(posedge ref_clk);
         #1 sink_unterminated = 6'h00;
         repeat (2) @(posedge ref_clk);
         #2 chk(pump, 1'b0);
      end
   endtask : t_pump

   task automatic t_shut;
      @(posedge ref_clk);
      #1 sink_unterminated = 6'h20;
      host_u.idle_low(OFF + 4);
      chk({shut, range_q, addr_q, pump}, {1'b1, 4'h0, 3'h1, 1'b0});
      host_u.burst(4);
      chk({shut, pump}, 2'h1);
      chk_grp(main_g, 4, LSS_SCALE_20);
      sink_unterminated = 6'h00;
   endtask : t_shut

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial
   begin
      err_count = 0;
      check_count = 0;
      reset = 1'b1;
      sink_unterminated = 6'h00;
      repeat (6) @(posedge ref_clk);
      #1 reset = 1'b0;
      @(posedge ref_clk);
      #2;
      t_default();
      t_range();
      t_groups();
      t_low();
      t_over();
      t_pump();
      t_shut();
      tally_and_finish();
   end

endmodule : testbench
`default_nettype wire
